/* File: shared/selfcal_seq_regs.vh */
`ifndef SELFCAL_SEQ_REGS_VH
`define SELFCAL_SEQ_REGS_VH

// ****************************************
// Sequence lengths, in input clock cycles
// ****************************************
`define PWR_CAL_CYCLES    105
`define M1_SEQ_CYCLES     62
`define M2_SEQ_CYCLES     24

// ****************************************
// Sequence cycle numbers, first cycle is 1
// ****************************************
`define OFS_STORE_CYCLE   1
`define OFS_LOAD_CYCLE    2
`define M1_CAPCAL_FIRST   3
`define M1_CAPCAL_LAST    40
`define M1_SAMPLE_FIRST   41
`define M1_SAMPLE_LAST    49
`define M2_SAMPLE_FIRST   3
`define M2_SAMPLE_LAST    10

// ****************************************
// Converter geometry
// ****************************************
`define SAR_BITS          13
`define DAC_BITS          8
`define CAL_CAPS          7
`define CNT_BITS          7

// ****************************************
// Correction RAM layout
// ****************************************
`define RAM_OFS_ADDR      3'h0
`define RAM_CAP_BASE      3'h1

// ****************************************
// Mode 2 command words, low six data bits
// ****************************************
`define CMD_CONVERT       6'h01
`define CMD_CALIBRATE     6'h02

`endif

/* File: hdl/step_counter.v */
`timescale 1ns/100ps
`include "selfcal_seq_regs.vh"

module step_counter #(
    parameter WIDTH = `CNT_BITS
) (
    input  wire             clk,
    input  wire             arst_n,
    input  wire             clear,
    input  wire             run,
    output reg  [WIDTH-1:0] count,
    output wire [WIDTH-1:0] next_count
);

    // Clear wins so a restart always begins at step zero
    assign next_count = clear ? {WIDTH{1'b0}} : (run ? count + {{(WIDTH-1){1'b0}}, 1'b1} : count);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= {WIDTH{1'b0}};
        end else begin
            count <= next_count;
        end
    end

endmodule

/* File: hdl/selfcal_adc_conversion_sequencer.v */
// Summary of operation
// - Each conversion opens with the coarse offset storage step and then loads the stored offset word into the DACs.
// - After offset correction both analog inputs are sampled onto the ladders before any bit decision.
// - Thirteen bits are decided, the error words of the seven top capacitors are fetched and those of the kept bits are accumulated.
// - The accumulator drives the correction DACs for the whole conversion.
// - In mode 1 a 105-cycle capacitor calibration runs on its own after power-up.
// - No conversion is carried out during the mode 1 power-up calibration.
// - In mode 2 there is no calibration at power-up; the host starts it with a command word.
// - In mode 2 a conversion command is accepted from the cycle after the boot cycle that follows power-up.
// - In mode 1 a conversion begins when chip select and write strobe are both low.
// - In mode 2 the command word is latched while chip select and write strobe are both low and acted on when either rises.
// - A low mode select input means mode 1 and a high one means mode 2.
// - A mode 1 sequence calibrates one capacitor and lasts 62 cycles.
// - A mode 2 conversion finishes at the end of cycle 24.
// - A new start during a conversion or a mode 2 calibration abandons it and restarts from the first step.
`timescale 1ns/100ps
`include "selfcal_seq_regs.vh"

module selfcal_adc_conversion_sequencer #(
    parameter CAL_CYCLES = `PWR_CAL_CYCLES
) (
    input  wire                     clk,
    input  wire                     arst_n,
    input  wire                     cs_n,
    input  wire                     wr_n,
    input  wire [5:0]               cmd_in,
    input  wire                     mode_sel,
    input  wire                     comp_keep,
    input  wire [`DAC_BITS-1:0]     ram_rdata,
    output reg                      busy,
    output reg                      cal_all,
    output reg                      offset_store,
    output reg                      sample_en,
    output reg                      cap_cal_en,
    output reg  [2:0]               cap_cal_idx,
    output reg                      ram_rd,
    output reg  [2:0]               ram_addr,
    output reg                      bit_decide,
    output reg  [3:0]               bit_idx,
    output reg  [`DAC_BITS-1:0]     dac_word,
    output reg  [`SAR_BITS-1:0]     conv_result,
    output reg                      conv_done,
    output reg                      cal_done
);

    // ****************************************
    // States
    // ****************************************
    localparam [1:0] ST_BOOT = 2'h0;
    localparam [1:0] ST_IDLE = 2'h1;
    localparam [1:0] ST_CAL  = 2'h2;
    localparam [1:0] ST_CONV = 2'h3;

    reg  [1:0]            state;
    reg  [1:0]            next_state;
    reg                   conv_mode2;
    reg                   next_mode2;
    reg                   sel_q;
    reg  [5:0]            cmd_word;
    reg  [`SAR_BITS-1:0]  sar_work;
    wire [`CNT_BITS-1:0]  count;
    wire [`CNT_BITS-1:0]  next_count;

    // True when the given count stands in sequence cycles lo..hi
    function in_cycles;
        input [`CNT_BITS-1:0] cnt;
        input [`CNT_BITS-1:0] lo;
        input [`CNT_BITS-1:0] hi;
        begin
            in_cycles = (cnt >= lo - 7'h01) && (cnt <= hi - 7'h01);
        end
    endfunction

    // Cuts a plain count down to the step counter width
    function [`CNT_BITS-1:0] to_cnt;
        input integer v;
        begin
            to_cnt = v[`CNT_BITS-1:0];
        end
    endfunction

    // ****************************************
    // Host strobes and start events
    // ****************************************
    wire sel_now    = !cs_n && !wr_n;
    wire sel_rise   = sel_now && !sel_q;
    wire sel_end    = !sel_now && sel_q;
    wire mode2_in   = mode_sel;
    wire m1_start   = !mode2_in && sel_rise;
    wire m2_conv    = mode2_in && sel_end && (cmd_word == `CMD_CONVERT);
    wire m2_cal     = mode2_in && sel_end && (cmd_word == `CMD_CALIBRATE);
    // Starts are ignored during power-up calibration and the boot cycle
    wire locked     = (state == ST_BOOT) || (state == ST_CAL && !conv_mode2);
    wire conv_start = (m1_start || m2_conv) && !locked;
    wire cal_start  = m2_cal && !locked;
    wire any_start  = conv_start || cal_start;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_q    <= 1'b0;
            cmd_word <= 6'h00;
        end else begin
            sel_q <= sel_now;
            if (sel_now) begin
                cmd_word <= cmd_in;
            end
        end
    end

    step_counter #(
        .WIDTH      (`CNT_BITS)
    ) u_step_counter (
        .clk        (clk),
        .arst_n     (arst_n),
        // Boot clears too, so power-up calibration counts from zero
        .clear      (any_start || state == ST_BOOT),
        .run        (next_state == ST_CONV || next_state == ST_CAL),
        .count      (count),
        .next_count (next_count)
    );

    wire [`CNT_BITS-1:0] seq_last = conv_mode2 ? to_cnt(`M2_SEQ_CYCLES - 1) : to_cnt(`M1_SEQ_CYCLES - 1);
    wire [`CNT_BITS-1:0] cal_last = to_cnt(CAL_CYCLES - 1);
    wire conv_end = (state == ST_CONV) && (count == seq_last) && !any_start;
    wire cal_end  = (state == ST_CAL) && (count == cal_last) && !any_start;

    // ****************************************
    // Sequence control
    // ****************************************
    always @* begin
        next_state = state;
        next_mode2 = conv_mode2;
        case (state)
            ST_BOOT: begin
                next_mode2 = mode2_in;
                next_state = mode2_in ? ST_IDLE : ST_CAL;
            end
            ST_IDLE, ST_CAL, ST_CONV: begin
                if (cal_end || conv_end) begin
                    next_state = ST_IDLE;
                end
                // A start aborts a running conversion or mode 2 calibration
                if (conv_start) begin
                    next_state = ST_CONV;
                    next_mode2 = mode2_in;
                end else if (cal_start) begin
                    next_state = ST_CAL;
                    next_mode2 = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= ST_BOOT;
            conv_mode2 <= 1'b0;
        end else begin
            state      <= next_state;
            conv_mode2 <= next_mode2;
        end
    end

    // ****************************************
    // Phase decode, aligned with the count
    // ****************************************
    reg                  next_offset_store;
    reg                  next_sample_en;
    reg                  next_cap_cal_en;
    reg                  next_ram_rd;
    reg  [2:0]           next_ram_addr;
    reg                  next_bit_decide;
    reg  [3:0]           next_bit_idx;
    reg  [`CNT_BITS-1:0] n_last;
    reg  [`CNT_BITS-1:0] dec_first;
    reg  [`CNT_BITS-1:0] rd_offs;

    always @* begin
        n_last            = next_mode2 ? to_cnt(`M2_SEQ_CYCLES) : to_cnt(`M1_SEQ_CYCLES);
        dec_first         = n_last - to_cnt(`SAR_BITS - 1);
        rd_offs           = next_count - (dec_first - 7'h02);
        next_offset_store = 1'b0;
        next_sample_en    = 1'b0;
        next_cap_cal_en   = 1'b0;
        next_ram_rd       = 1'b0;
        next_ram_addr     = `RAM_OFS_ADDR;
        next_bit_decide   = 1'b0;
        next_bit_idx      = 4'h0;
        if (next_state == ST_CONV) begin
            next_offset_store = in_cycles(next_count, to_cnt(`OFS_STORE_CYCLE), to_cnt(`OFS_STORE_CYCLE));
            if (next_offset_store) begin
                next_ram_rd = 1'b1;
            end
            if (next_mode2) begin
                next_sample_en = in_cycles(next_count, to_cnt(`M2_SAMPLE_FIRST), to_cnt(`M2_SAMPLE_LAST));
            end else begin
                next_sample_en  = in_cycles(next_count, to_cnt(`M1_SAMPLE_FIRST), to_cnt(`M1_SAMPLE_LAST));
                next_cap_cal_en = in_cycles(next_count, to_cnt(`M1_CAPCAL_FIRST), to_cnt(`M1_CAPCAL_LAST));
            end
            // Error words are fetched one cycle ahead of each top-bit decision
            if (in_cycles(next_count, dec_first - 7'h01, dec_first + to_cnt(`CAL_CAPS - 2))) begin
                next_ram_rd   = 1'b1;
                next_ram_addr = `RAM_CAP_BASE + rd_offs[2:0];
            end
            if (in_cycles(next_count, dec_first, n_last)) begin
                next_bit_decide = 1'b1;
                next_bit_idx    = n_last[3:0] - 4'h1 - next_count[3:0];
            end
        end
    end

    wire top_bit = bit_idx >= (`SAR_BITS - `CAL_CAPS);

    // ****************************************
    // Registered outputs and datapath
    // ****************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy         <= 1'b1;
            cal_all      <= 1'b0;
            offset_store <= 1'b0;
            sample_en    <= 1'b0;
            cap_cal_en   <= 1'b0;
            cap_cal_idx  <= 3'h0;
            ram_rd       <= 1'b0;
            ram_addr     <= 3'h0;
            bit_decide   <= 1'b0;
            bit_idx      <= 4'h0;
            dac_word     <= 8'h00;
            sar_work     <= 13'h0000;
            conv_result  <= 13'h0000;
            conv_done    <= 1'b0;
            cal_done     <= 1'b0;
        end else begin
            busy         <= (next_state != ST_IDLE);
            cal_all      <= (next_state == ST_CAL);
            offset_store <= next_offset_store;
            sample_en    <= next_sample_en;
            cap_cal_en   <= next_cap_cal_en;
            ram_rd       <= next_ram_rd;
            ram_addr     <= next_ram_addr;
            bit_decide   <= next_bit_decide;
            bit_idx      <= next_bit_idx;
            conv_done    <= conv_end;
            cal_done     <= cal_end;
            if (state == ST_CONV && !any_start && count == `OFS_LOAD_CYCLE - 1) begin
                dac_word <= ram_rdata;
            end else if (bit_decide && comp_keep && top_bit && !any_start) begin
                // Wraps at eight bits, like the DAC it feeds
                dac_word <= dac_word + ram_rdata;
            end
            if (conv_start) begin
                sar_work <= 13'h0000;
            end else if (bit_decide) begin
                sar_work[bit_idx] <= comp_keep;
            end
            if (conv_end) begin
                conv_result <= sar_work | ({{(`SAR_BITS-1){1'b0}}, comp_keep} << bit_idx);
            end
            // Index moves on only once the capacitor has really been calibrated
            if (state == ST_CONV && !conv_mode2 && !any_start && count == `M1_CAPCAL_LAST - 1) begin
                cap_cal_idx <= (cap_cal_idx == `CAL_CAPS - 1) ? 3'h0 : cap_cal_idx + 3'h1;
            end
        end
    end

endmodule

/* File: bench/seq_monitor.sv */
`timescale 1ns/100ps
`include "selfcal_seq_regs.vh"
module seq_monitor #(
    parameter CAL_CYCLES = `PWR_CAL_CYCLES
) (
    input wire                 clk,
    input wire                 arst_n,
    input wire                 cs_n,
    input wire                 wr_n,
    input wire                 mode_sel,
    input wire                 comp_keep,
    input wire [`DAC_BITS-1:0] ram_rdata,
    input wire                 busy,
    input wire                 cal_all,
    input wire                 sample_en,
    input wire                 cap_cal_en,
    input wire                 offset_store,
    input wire                 ram_rd,
    input wire [2:0]           ram_addr,
    input wire                 bit_decide,
    input wire [3:0]           bit_idx,
    input wire [`DAC_BITS-1:0] dac_word,
    input wire                 conv_done,
    input wire                 cal_done
);
    reg [7:0] cal_cnt;
    reg [6:0] seq_age;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ****************
    // Properties
    // ****************
    // Aborting a calibration would upset this count
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            cal_cnt <= 8'h00;
        else
            cal_cnt <= cal_all ? cal_cnt + 8'h01 : 8'h00;
    end
    property p_ofs_read;
        offset_store && !cal_all |-> ram_rd && ram_addr == `RAM_OFS_ADDR;
    endproperty
    a_ofs_read: assert property (p_ofs_read) else $error("no offset read");
    property p_dac_load;
        offset_store ##1 1'b1 ##1 !offset_store |-> dac_word == $past(ram_rdata);
    endproperty
    a_dac_load: assert property (p_dac_load) else $error("offset not loaded");
    property p_bit_order;
        bit_decide && bit_idx != 4'h0 |=> offset_store || (bit_decide && bit_idx == $past(bit_idx) - 4'h1);
    endproperty
    a_bit_order: assert property (p_bit_order) else $error("bit order");
    property p_accum;
        bit_decide && bit_idx >= 4'h6 && comp_keep |=> offset_store || dac_word == $past(dac_word) + $past(ram_rdata);
    endproperty
    a_accum: assert property (p_accum) else $error("accumulate");
    property p_seq_len;
        conv_done |-> (mode_sel ? $past(offset_store, `M2_SEQ_CYCLES) : $past(offset_store, `M1_SEQ_CYCLES));
    endproperty
    a_seq_len: assert property (p_seq_len) else $error("sequence length");
    property p_cal_len;
        $fell(cal_all) |-> cal_done && cal_cnt == CAL_CYCLES;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length");
    property p_cal_quiet;
        cal_all |-> !bit_decide && !conv_done;
    endproperty
    a_cal_quiet: assert property (p_cal_quiet) else $error("conversion in calibration");
    property p_m1_start;
        !mode_sel && !cal_all && !cs_n && !wr_n && $past(cs_n || wr_n) |=> offset_store;
    endproperty
    a_m1_start: assert property (p_m1_start) else $error("start missed");
    // Cycles since the offset step; held at the top so it never wraps
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            seq_age <= 7'h00;
        else if (offset_store)
            seq_age <= 7'h01;
        else if (seq_age != 7'h7F)
            seq_age <= seq_age + 7'h01;
    end
    property p_sample_win;
        busy && !cal_all |-> sample_en == (!offset_store && (mode_sel ?
            (seq_age >= `M2_SAMPLE_FIRST - 1 && seq_age <= `M2_SAMPLE_LAST - 1) :
            (seq_age >= `M1_SAMPLE_FIRST - 1 && seq_age <= `M1_SAMPLE_LAST - 1)));
    endproperty
    a_sample_win: assert property (p_sample_win) else $error("sampling window");
    property p_capcal_win;
        busy && !cal_all |-> cap_cal_en == (!offset_store && !mode_sel &&
            seq_age >= `M1_CAPCAL_FIRST - 1 && seq_age <= `M1_CAPCAL_LAST - 1);
    endproperty
    a_capcal_win: assert property (p_capcal_win) else $error("capacitor calibration window");
endmodule
bind selfcal_adc_conversion_sequencer seq_monitor #(.CAL_CYCLES(CAL_CYCLES)) mon (
    .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .wr_n(wr_n), .mode_sel(mode_sel), .comp_keep(comp_keep),
    .busy(busy), .sample_en(sample_en), .cap_cal_en(cap_cal_en),
    .ram_rdata(ram_rdata), .cal_all(cal_all), .offset_store(offset_store), .ram_rd(ram_rd), .ram_addr(ram_addr),
    .bit_decide(bit_decide), .bit_idx(bit_idx), .dac_word(dac_word), .conv_done(conv_done), .cal_done(cal_done)
);

/* File: bench/host_model.sv */
`timescale 1ns/100ps
// ****************
// Host strobes and correction RAM
// ****************
module host_model (
    input  wire       clk,
    input  wire       ram_rd,
    input  wire [2:0] ram_addr,
    output wire       cs_n,
    output wire       wr_n,
    output reg  [5:0] cmd_in,
    output reg  [7:0] ram_rdata
);
    reg stb_n = 1'b1;
    assign cs_n = stb_n;
    assign wr_n = stb_n;
    initial cmd_in = 6'h00;
    initial ram_rdata = 8'h00;
    // Idle bus toggles so a late sample never sees the old word
    always @(posedge clk)
        ram_rdata <= ram_rd ? {ram_addr, 5'h13} : ~ram_rdata;
    task m1_start;
        begin
            @(negedge clk) stb_n = 1'b0;
            @(negedge clk) stb_n = 1'b1;
        end
    endtask
    task m2_write(input [5:0] c);
        begin
            @(negedge clk) stb_n = 1'b0;
            cmd_in = c;
            @(negedge clk) stb_n = 1'b1;
            @(negedge clk) cmd_in = ~c;
        end
    endtask
endmodule

/* File: bench/tb.sv */
`timescale 1ns/100ps
`include "selfcal_seq_regs.vh"
module tb;
    localparam CAL = 8;
    localparam [12:0] PAT = 13'h1A5B;
    // Offset word plus errors of kept top bits 12, 11, 9 and 6, wrapped to eight bits
    localparam [7:0]  ACC = 8'h13 + 8'h33 + 8'h53 + 8'h93 + 8'hF3;
    reg         clk, arst_n, mode_sel;
    reg         comp_keep = 1'b0;
    wire        busy, cal_all, offset_store, sample_en, cap_cal_en, ram_rd, bit_decide, conv_done, cal_done, cs_n, wr_n;
    wire [2:0]  cap_cal_idx, ram_addr;
    wire [3:0]  bit_idx;
    wire [5:0]  cmd_in;
    wire [7:0]  dac_word, ram_rdata;
    wire [12:0] conv_result;
    integer     bad_count = 0, num_checks = 0, cyc = 0, n;
    reg  [2:0]  i0;
    selfcal_adc_conversion_sequencer #(.CAL_CYCLES(CAL)) DUT (
        .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .wr_n(wr_n), .cmd_in(cmd_in), .mode_sel(mode_sel),
        .comp_keep(comp_keep), .ram_rdata(ram_rdata), .busy(busy), .cal_all(cal_all), .offset_store(offset_store),
        .sample_en(sample_en), .cap_cal_en(cap_cal_en), .cap_cal_idx(cap_cal_idx), .ram_rd(ram_rd),
        .ram_addr(ram_addr), .bit_decide(bit_decide), .bit_idx(bit_idx), .dac_word(dac_word),
        .conv_result(conv_result), .conv_done(conv_done), .cal_done(cal_done)
    );
    host_model host (.clk(clk), .ram_rd(ram_rd), .ram_addr(ram_addr), .cs_n(cs_n), .wr_n(wr_n),
                     .cmd_in(cmd_in), .ram_rdata(ram_rdata));
    // ****************
    // Helpers
    // ****************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Comparator keeps a fixed bit pattern
    always @(negedge clk)
        comp_keep <= bit_decide ? PAT[bit_idx] : 1'b0;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            bad_count = bad_count + 1;
            print_verdict;
        end
    end
    function [2:0] nxt(input [2:0] v);
        nxt = (v == 3'h6) ? 3'h0 : v + 3'h1;
    endfunction
    task check(input [15:0] seen, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wait_sig(input w);
        begin
            n = 1;
            @(posedge clk);
            #1;
            while (n < 300 && (w ? cal_done : conv_done) !== 1'b1) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
        end
    endtask
    task do_reset(input m);
        begin
            arst_n = 1'b0;
            mode_sel = m;
            repeat (5) @(negedge clk);
            arst_n = 1'b1;
        end
    endtask
    task print_verdict;
        begin
            $display("checks=%0d errors=%0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    task t_boot;
        begin
            do_reset(1'b0);
            repeat (3) @(negedge clk);
            host.m1_start;
            check(offset_store, 1'b0);
            check(busy, 1'b1);
            wait_sig(1'b1);
            check(n < 300, 1'b1);
            repeat (2) @(negedge clk);
            check(busy, 1'b0);
        end
    endtask
    task t_conv;
        begin
            i0 = cap_cal_idx;
            host.m1_start;
            check(offset_store, 1'b1);
            wait_sig(1'b0);
            check(n, `M1_SEQ_CYCLES);
            check(conv_result, PAT);
            check(dac_word, ACC);
            @(negedge clk);
            check(cap_cal_idx, nxt(i0));
        end
    endtask
    task t_abort(input integer k);
        begin
            i0 = cap_cal_idx;
            host.m1_start;
            repeat (k) @(negedge clk);
            host.m1_start;
            check(offset_store, 1'b1);
            wait_sig(1'b0);
            check(n, `M1_SEQ_CYCLES);
            @(negedge clk);
            check(cap_cal_idx, k < 30 ? nxt(i0) : nxt(nxt(i0)));
        end
    endtask
    task t_mode2;
        begin
            do_reset(1'b1);
            host.m2_write(`CMD_CONVERT);
            check(offset_store, 1'b1);
            check(cal_all, 1'b0);
            wait_sig(1'b0);
            check(n, `M2_SEQ_CYCLES);
            check(conv_result, PAT);
            check(dac_word, ACC);
            host.m2_write(`CMD_CALIBRATE);
            check(cal_all, 1'b1);
            wait_sig(1'b1);
            check(n, CAL);
            host.m2_write(6'h3F);
            check(busy, 1'b0);
        end
    endtask
    initial begin
        t_boot;
        repeat (8) t_conv;
        t_abort(20);
        t_abort(45);
        t_mode2;
        print_verdict;
    end
endmodule
